/* rtl/phm_evt_if.sv */
// Purpose: Carries latch events and the internal reset request between modules.
// Assumes: All members are synchronous to mclk.
// Notes: view is combinational from the latch module.
`timescale 1ns/10ps
interface phm_evt_if #(parameter int N = 5);
	logic [N-1:0] live;
	logic [N-1:0] view;
	logic clr_stat;
	logic clr_exp;
	logic reset_req;
	logic core_reset;
	modport regs(output live, output clr_stat, output clr_exp, output reset_req,
		input view, input core_reset);
	modport latch(input live, input clr_stat, input clr_exp, output view);
	modport rst(input reset_req, output core_reset);
endinterface

/* rtl/phm_latch.sv */
// Purpose: Latch-high and latch-low holding of status events until read.
// Assumes: Clear strobe arrives in the cycle the register is read.
// Notes: A new event in the clear cycle is kept.
`timescale 1ns/10ps
module phm_latch (
	input wire logic mclk,
	input wire logic arst_n,
	phm_evt_if.latch ev
);
	typedef struct packed {
		logic [phm_pkg::LAT_N-1:0] held;
	} phm_lat_st_t;

	phm_lat_st_t st;
	phm_lat_st_t next_st;
	logic hit;
	logic clr;

	always_comb begin
		next_st = st;
		hit = 1'b0;
		clr = 1'b0;
		for (int i = 0; i < phm_pkg::LAT_N; i++) begin
			hit = phm_pkg::LAT_LOW_MASK[i] ? !ev.live[i] : ev.live[i];
			clr = phm_pkg::LAT_IN_STAT[i] ? ev.clr_stat : ev.clr_exp;
			next_st.held[i] = (st.held[i] & !clr) | hit;
			ev.view[i] = phm_pkg::LAT_LOW_MASK[i] ? (ev.live[i] & !st.held[i])
				: (ev.live[i] | st.held[i]);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* rtl/phm_pkg.sv */
// Purpose: Shared constants for the standard management register bank.
// Assumes: 16-bit registers, 5-bit register number, one 250 MHz clock.
// Notes: Bit positions are plain ints; field values are sized to their fields.
package phm_pkg;
	// ----------------------------------------
	// Address space
	// ----------------------------------------
	localparam int REG_COUNT = 32;
	localparam int STD_COUNT = 16;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h01;
	localparam logic [4:0] OFS_IDH = 5'h02;
	localparam logic [4:0] OFS_IDL = 5'h03;
	localparam logic [4:0] OFS_ADV = 5'h04;
	localparam logic [4:0] OFS_LPA = 5'h05;
	localparam logic [4:0] OFS_EXP = 5'h06;
	localparam logic [4:0] OFS_NPT = 5'h07;
	localparam logic [4:0] OFS_XSTAT = 5'h0F;
	localparam logic [4:0] OFS_MDIX = 5'h1C;

	// ----------------------------------------
	// Basic control
	// ----------------------------------------
	localparam int CTL_RESET = 15;
	localparam int CTL_LOOP = 14;
	localparam int CTL_SPD_LSB = 13;
	localparam int CTL_AN_EN = 12;
	localparam int CTL_PDOWN = 11;
	localparam int CTL_ISO = 10;
	localparam int CTL_AN_RST = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_SPD_MSB = 6;
	localparam logic [15:0] CTRL_RST = 16'h1100;
	localparam logic [15:0] CTRL_WMASK = 16'h7DC0;
	localparam logic [1:0] SPD_1000 = 2'h2;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_10 = 2'h0;

	// ----------------------------------------
	// Basic status and extended status
	// ----------------------------------------
	localparam logic [15:0] STAT_FIXED = 16'h7949;
	localparam int STAT_AN_DONE = 5;
	localparam int STAT_RFAULT = 4;
	localparam int STAT_LINK = 2;
	localparam int STAT_JABBER = 1;
	localparam logic [15:0] XSTAT_FIXED = 16'h3000;

	// ----------------------------------------
	// Advertisement, partner, expansion, next page
	// ----------------------------------------
	localparam logic [15:0] ADV_RST = 16'h01E1;
	localparam logic [15:0] ADV_WMASK = 16'hADFF;
	localparam int ADV_RFAULT = 13;
	localparam int ADV_PAUSE_LO = 10;
	localparam logic [1:0] PAUSE_NONE = 2'h0;
	localparam logic [1:0] PAUSE_ASYM = 2'h2;
	localparam logic [1:0] PAUSE_SYM = 2'h1;
	localparam logic [1:0] PAUSE_BOTH = 2'h3;
	localparam int LPA_ACK = 14;
	localparam logic [15:0] LPA_RST = 16'h0000;
	localparam int EXP_PDF = 4;
	localparam int EXP_LP_NP = 3;
	localparam int EXP_NP_ABLE = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LP_AN = 0;
	localparam logic [15:0] NPT_RST = 16'h2001;
	localparam logic [15:0] NPT_WMASK = 16'hB7FF;
	localparam int NPT_TOGGLE = 11;
	localparam int NPT_MSG_W = 11;

	// ----------------------------------------
	// Crossover control
	// ----------------------------------------
	localparam int MDIX_SEL = 7;
	localparam int MDIX_SWAP_OFF = 6;
	localparam logic [15:0] MDIX_RST = 16'h0000;
	localparam logic [15:0] MDIX_WMASK = 16'h00C0;

	// ----------------------------------------
	// Latched status bits
	// ----------------------------------------
	localparam int LAT_N = 5;
	localparam int LAT_LINK = 0;
	localparam int LAT_JAB = 1;
	localparam int LAT_RF = 2;
	localparam int LAT_PDF = 3;
	localparam int LAT_PGRX = 4;
	localparam logic [4:0] LAT_LOW_MASK = 5'h01;
	localparam logic [4:0] LAT_IN_STAT = 5'h07;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int PD_WAIT_MS = 1;
	localparam int PD_WAIT_CYC = PD_WAIT_MS * CLK_MHZ * 1000;
endpackage

/* rtl/phm_regs.sv */
// Purpose: Standard management register bank of a triple-speed transceiver.
// Assumes: Register port is pre-decoded from management frames, synchronous.
// Notes: Registers not implemented here read as zero and ignore writes.
//
// How it works
// - 32 register numbers, low 16 standard
// - Soft reset bit resets, reads zero
// - Restart bit restarts negotiation, self-clears
// - Speed MSB/LSB encoding; MSB from strap
// - Negotiation enabled overrides forced speed/duplex
// - Negotiation off disables automatic crossover
// - Power-down; leaving it issues global reset
// - Isolate bit cuts the MAC interface
// - Jabber bit latches high, resets zero
// - Negotiation complete bit reads live
// - Basic status reports fixed abilities
// - Parallel detection fault latches high
// - Local next-page able constant, partner shown
// - Pause field encoding, resets to none
// - Remote fault support bit, resets zero
// - Partner page captured, acknowledge set
// - Next page: 11-bit message, resets 0x2001
// - Toggle bit read-only, device maintained
// - Self-clear, latch-high, latch-low honoured
`timescale 1ns/10ps
module phm_regs #(
	// Identifier defaults are arbitrary
	parameter logic [15:0] ID_HIGH = 16'h1234,
	parameter logic [15:0] ID_LOW = 16'h5678,
	parameter int HOLD_CYC = phm_pkg::PD_WAIT_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic strap_speed_msb,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic an_done,
	input wire logic [1:0] an_speed,
	input wire logic an_duplex,
	input wire logic link_up,
	input wire logic jabber,
	input wire logic remote_fault,
	input wire logic par_det_fault,
	input wire logic page_rx,
	input wire logic lp_page_valid,
	input wire logic [15:0] lp_page,
	input wire logic lp_np_able,
	input wire logic lp_an_able,
	input wire logic np_sent,
	output logic core_reset,
	output logic an_restart,
	output logic an_enable,
	output logic loopback,
	output logic isolate,
	output logic power_down,
	output logic [1:0] speed_sel,
	output logic duplex_full,
	output logic mdix_auto,
	output logic mdix_manual_sel,
	output logic [15:0] adv_word,
	output logic [15:0] np_word
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] adv;
		logic [15:0] lpa;
		logic [15:0] npt;
		logic [15:0] mdix;
		logic lp_np;
		logic lp_an;
		logic strap_done;
		logic rst_req;
		logic an_restart;
		logic [1:0] speed;
		logic duplex;
		logic mdix_auto;
		logic [15:0] rd_data;
		logic rd_valid;
	} phm_reg_st_t;

	phm_reg_st_t st;
	phm_reg_st_t next_st;
	logic [15:0] rd_mux;
	logic [15:0] ctrl_new;

	phm_evt_if #(.N(phm_pkg::LAT_N)) ev ();

	phm_latch u_latch (
		.mclk(mclk),
		.arst_n(arst_n),
		.ev(ev)
	);

	phm_reset_ctl #(.HOLD_CYC(HOLD_CYC)) u_rst (
		.mclk(mclk),
		.arst_n(arst_n),
		.ev(ev)
	);

	// ----------------------------------------
	// Event and clear wiring
	// ----------------------------------------
	always_comb begin
		ev.live = '0;
		ev.live[phm_pkg::LAT_JAB] = jabber;
		ev.live[phm_pkg::LAT_LINK] = link_up;
		ev.live[phm_pkg::LAT_RF] = remote_fault;
		ev.live[phm_pkg::LAT_PDF] = par_det_fault;
		ev.live[phm_pkg::LAT_PGRX] = page_rx;
		ev.clr_stat = reg_rd && (reg_addr == phm_pkg::OFS_STAT);
		ev.clr_exp = reg_rd && (reg_addr == phm_pkg::OFS_EXP);
		ev.reset_req = st.rst_req;
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Full 32-entry decode
	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr)
			phm_pkg::OFS_CTRL: begin
				rd_mux = st.ctrl;
			end
			phm_pkg::OFS_STAT: begin
				rd_mux = phm_pkg::STAT_FIXED;
				rd_mux[phm_pkg::STAT_AN_DONE] = an_done;
				rd_mux[phm_pkg::STAT_RFAULT] = ev.view[phm_pkg::LAT_RF];
				rd_mux[phm_pkg::STAT_LINK] = ev.view[phm_pkg::LAT_LINK];
				rd_mux[phm_pkg::STAT_JABBER] = ev.view[phm_pkg::LAT_JAB];
			end
			phm_pkg::OFS_IDH: begin
				rd_mux = ID_HIGH;
			end
			phm_pkg::OFS_IDL: begin
				rd_mux = ID_LOW;
			end
			phm_pkg::OFS_ADV: begin
				rd_mux = st.adv;
			end
			phm_pkg::OFS_LPA: begin
				rd_mux = st.lpa;
			end
			phm_pkg::OFS_EXP: begin
				rd_mux[phm_pkg::EXP_PDF] = ev.view[phm_pkg::LAT_PDF];
				rd_mux[phm_pkg::EXP_LP_NP] = st.lp_np;
				rd_mux[phm_pkg::EXP_NP_ABLE] = 1'b1;
				rd_mux[phm_pkg::EXP_PAGE_RX] = ev.view[phm_pkg::LAT_PGRX];
				rd_mux[phm_pkg::EXP_LP_AN] = st.lp_an;
			end
			phm_pkg::OFS_NPT: begin
				rd_mux = st.npt;
			end
			phm_pkg::OFS_XSTAT: begin
				rd_mux = phm_pkg::XSTAT_FIXED;
			end
			phm_pkg::OFS_MDIX: begin
				rd_mux = st.mdix;
			end
			default: begin
				rd_mux = 16'h0000;
			end
		endcase
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.rst_req = 1'b0;
		next_st.an_restart = 1'b0;
		next_st.rd_valid = reg_rd;
		ctrl_new = (reg_wdata & phm_pkg::CTRL_WMASK) | (st.ctrl & ~phm_pkg::CTRL_WMASK);
		if (reg_rd) begin
			next_st.rd_data = rd_mux;
		end
		// Strap is sampled once after release and again at each global reset, never under the async reset
		if (!st.strap_done) begin
			next_st.strap_done = 1'b1;
			next_st.ctrl[phm_pkg::CTL_SPD_MSB] = strap_speed_msb;
		end
		if (st.rst_req) begin
			// Global reset reloads defaults; a write in this cycle is dropped
			next_st.ctrl = phm_pkg::CTRL_RST;
			next_st.ctrl[phm_pkg::CTL_SPD_MSB] = strap_speed_msb;
			next_st.adv = phm_pkg::ADV_RST;
			next_st.lpa = phm_pkg::LPA_RST;
			next_st.npt = phm_pkg::NPT_RST;
			next_st.mdix = phm_pkg::MDIX_RST;
			next_st.lp_np = 1'b0;
			next_st.lp_an = 1'b0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					phm_pkg::OFS_CTRL: begin
						next_st.ctrl = ctrl_new;
						next_st.rst_req = reg_wdata[phm_pkg::CTL_RESET]
							|| (st.ctrl[phm_pkg::CTL_PDOWN] && !reg_wdata[phm_pkg::CTL_PDOWN]);
						next_st.an_restart = reg_wdata[phm_pkg::CTL_AN_RST];
					end
					phm_pkg::OFS_ADV: begin
						next_st.adv = (reg_wdata & phm_pkg::ADV_WMASK)
							| (st.adv & ~phm_pkg::ADV_WMASK);
					end
					phm_pkg::OFS_NPT: begin
						next_st.npt = (reg_wdata & phm_pkg::NPT_WMASK)
							| (st.npt & ~phm_pkg::NPT_WMASK);
					end
					phm_pkg::OFS_MDIX: begin
						next_st.mdix = reg_wdata & phm_pkg::MDIX_WMASK;
					end
					default: begin
						next_st.ctrl = next_st.ctrl;
					end
				endcase
			end
			if (lp_page_valid) begin
				next_st.lpa = lp_page;
				next_st.lpa[phm_pkg::LPA_ACK] = 1'b1;
			end
			next_st.lp_np = lp_np_able;
			next_st.lp_an = lp_an_able;
			if (np_sent) begin
				next_st.npt[phm_pkg::NPT_TOGGLE] = !st.npt[phm_pkg::NPT_TOGGLE];
			end
		end
		if (next_st.ctrl[phm_pkg::CTL_AN_EN]) begin
			next_st.speed = an_speed;
			next_st.duplex = an_duplex;
		end else begin
			next_st.speed = {next_st.ctrl[phm_pkg::CTL_SPD_MSB],
				next_st.ctrl[phm_pkg::CTL_SPD_LSB]};
			next_st.duplex = next_st.ctrl[phm_pkg::CTL_DUPLEX];
		end
		next_st.mdix_auto = next_st.ctrl[phm_pkg::CTL_AN_EN]
			&& !next_st.mdix[phm_pkg::MDIX_SWAP_OFF];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.ctrl <= phm_pkg::CTRL_RST;
			st.adv <= phm_pkg::ADV_RST;
			st.lpa <= phm_pkg::LPA_RST;
			st.npt <= phm_pkg::NPT_RST;
			st.mdix <= phm_pkg::MDIX_RST;
			st.mdix_auto <= 1'b1;
			st.duplex <= 1'b0;
			st.speed <= phm_pkg::SPD_10;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = st.rd_data;
	assign reg_rvalid = st.rd_valid;
	// Held by the reset counter flop; long enough to cover the host wait
	assign core_reset = ev.core_reset;
	assign an_restart = st.an_restart;
	assign an_enable = st.ctrl[phm_pkg::CTL_AN_EN];
	assign loopback = st.ctrl[phm_pkg::CTL_LOOP];
	assign isolate = st.ctrl[phm_pkg::CTL_ISO];
	assign power_down = st.ctrl[phm_pkg::CTL_PDOWN];
	assign speed_sel = st.speed;
	assign duplex_full = st.duplex;
	assign mdix_auto = st.mdix_auto;
	assign mdix_manual_sel = st.mdix[phm_pkg::MDIX_SEL];
	assign adv_word = st.adv;
	assign np_word = st.npt;
endmodule

/* rtl/phm_reset_ctl.sv */
// Purpose: Stretches an internal reset request into a held core reset.
// Assumes: Request is a one-cycle pulse.
// Notes: Hold length is a parameter so simulation can shorten it.
`timescale 1ns/10ps
module phm_reset_ctl #(
	parameter int HOLD_CYC = phm_pkg::PD_WAIT_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	phm_evt_if.rst ev
);
	localparam int CW = $clog2(HOLD_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic active;
	} phm_rst_st_t;

	phm_rst_st_t st;
	phm_rst_st_t next_st;

	always_comb begin
		next_st = st;
		if (ev.reset_req) begin
			next_st.cnt = CW'(HOLD_CYC - 1);
			next_st.active = 1'b1;
		end else if (st.cnt != '0) begin
			next_st.cnt = st.cnt - CW'(1);
		end else begin
			next_st.active = 1'b0;
		end
	end

	assign ev.core_reset = st.active;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* verif/phm_host.sv */
// Purpose: Station management host model on the register port.
// Assumes: Strobes change at the falling edge, one cycle long.
// Notes: Sets tmo when a read answer never comes.
`timescale 1ns/10ps
module phm_host (
	input wire logic mclk,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	localparam logic [15:0] PD_STAT_MASK = 16'hFFFB;
	logic tmo;
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tmo = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		// Stale data would hide a late sample
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
			@(negedge mclk);
		tmo = reg_rvalid !== 1'b1;
		d = reg_rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge mclk);
	endtask
endmodule

/* verif/phm_regs_chk.sv */
// Purpose: Port assertions for the management register bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Hold length arrives as a parameter through the bind.
`timescale 1ns/10ps
module phm_regs_chk #(
	parameter int HOLD_CYC = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [1:0] an_speed,
	input wire logic an_duplex,
	input wire logic np_sent,
	input wire logic core_reset,
	input wire logic an_restart,
	input wire logic an_enable,
	input wire logic power_down,
	input wire logic [1:0] speed_sel,
	input wire logic duplex_full,
	input wire logic mdix_auto,
	input wire logic [15:0] adv_word,
	input wire logic [15:0] np_word
);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	int hold_cnt;
	logic ctl_wr;
	assign ctl_wr = reg_wr && reg_addr == 5'h00;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Counter, since a repetition count cannot be a parameter
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			hold_cnt <= 0;
		else
			hold_cnt <= core_reset ? hold_cnt + 1 : 0;
	end
	sequence s_soft_req;
		ctl_wr && reg_wdata[15];
	endsequence
	sequence s_one_pulse;
		an_restart ##1 !an_restart;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without request");
	a_soft_reset: assert property (s_soft_req |-> ##2 core_reset)
		else $error("soft reset not applied");
	a_restart_pulse: assert property (
		ctl_wr && reg_wdata[9] && !reg_wdata[15] |=> s_one_pulse)
		else $error("restart not a single pulse");
	a_an_override: assert property (
		$past(arst_n) && an_enable && $past(an_enable) && !core_reset && !$past(core_reset)
		|-> speed_sel == $past(an_speed) && duplex_full == $past(an_duplex))
		else $error("negotiated result not applied");
	a_mdix_off: assert property (
		ctl_wr && !reg_wdata[12] && !reg_wdata[15] |=> !an_enable && !mdix_auto)
		else $error("auto crossover left on");
	a_pd_exit: assert property ($fell(power_down) |-> ##[0:2] core_reset)
		else $error("no reset after power-down exit");
	a_hold_len: assert property ($fell(core_reset) |-> hold_cnt == HOLD_CYC)
		else $error("core reset hold length wrong");
	a_adv_write: assert property (
		reg_wr && reg_addr == 5'h04 |=> adv_word == ($past(reg_wdata) & phm_pkg::ADV_WMASK))
		else $error("advertisement write wrong");
	a_np_message: assert property (
		reg_wr && reg_addr == 5'h07 |=> (np_word & 16'h07FF) == ($past(reg_wdata) & 16'h07FF))
		else $error("message field write wrong");
	a_toggle_flip: assert property (np_sent |=> np_word[11] != $past(np_word[11]))
		else $error("toggle bit did not flip");
endmodule

bind phm_regs phm_regs_chk #(.HOLD_CYC(HOLD_CYC)) phm_regs_chk_inst (.mclk(mclk),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .an_speed(an_speed), .an_duplex(an_duplex),
	.np_sent(np_sent), .core_reset(core_reset), .an_restart(an_restart),
	.an_enable(an_enable), .power_down(power_down), .speed_sel(speed_sel),
	.duplex_full(duplex_full), .mdix_auto(mdix_auto), .adv_word(adv_word), .np_word(np_word));

/* verif/tb.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: Core reset hold shortened to 8 cycles.
// Notes: Partner inputs are levels and pulses driven at the falling edge.
`timescale 1ns/10ps
module tb;
	localparam int HOLD = 8;
	logic mclk;
	logic arst_n;
	logic strap;
	logic [3:0] ev;
	logic link_up;
	logic an_done;
	logic [1:0] an_speed;
	logic an_duplex;
	logic lp_page_valid;
	logic [15:0] lp_page;
	logic lp_np_able;
	logic lp_an_able;
	logic np_sent;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic core_reset;
	logic an_restart;
	logic an_enable;
	logic loopback;
	logic isolate;
	logic power_down;
	logic [1:0] speed_sel;
	logic duplex_full;
	logic mdix_auto;
	logic mdix_manual_sel;
	logic [15:0] adv_word;
	logic [15:0] np_word;
	int error_cnt;
	int comparisons;
	phm_host phm_host_inst (.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	// Identifier values are arbitrary
	phm_regs #(.ID_HIGH(16'hC3A5), .ID_LOW(16'h5A3C), .HOLD_CYC(HOLD)) phm_regs_inst (
		.mclk(mclk), .arst_n(arst_n), .strap_speed_msb(strap), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .an_done(an_done), .an_speed(an_speed),
		.an_duplex(an_duplex), .link_up(link_up), .jabber(ev[0]), .remote_fault(ev[1]),
		.par_det_fault(ev[2]), .page_rx(ev[3]), .lp_page_valid(lp_page_valid),
		.lp_page(lp_page), .lp_np_able(lp_np_able), .lp_an_able(lp_an_able), .np_sent(np_sent),
		.core_reset(core_reset), .an_restart(an_restart), .an_enable(an_enable),
		.loopback(loopback), .isolate(isolate), .power_down(power_down),
		.speed_sel(speed_sel), .duplex_full(duplex_full), .mdix_auto(mdix_auto),
		.mdix_manual_sel(mdix_manual_sel), .adv_word(adv_word), .np_word(np_word));
	always #2 mclk = ~mclk;
	task automatic test_done();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdm(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
		logic [15:0] d;
		phm_host_inst.rd(a, d);
		chk("reg_rdata", e & m, d & m);
		// A missing answer is a failure even if stale data happens to match
		if (phm_host_inst.tmo) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		rdm(a, e, 16'hFFFF);
	endtask
	task automatic wait_cr(input logic lvl);
		for (int i = 0; i < 40 && core_reset !== lvl; i++)
			@(negedge mclk);
		chk("core_reset", {15'h0, lvl}, {15'h0, core_reset});
		if (core_reset !== lvl)
			test_done();
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		logic [4:0] a[11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0F,
			5'h10, 5'h1C};
		logic [15:0] e[11] = '{16'h1140, 16'h794D, 16'hC3A5, 16'h5A3C, 16'h01E1, 16'h0000,
			16'h0005, 16'h2001, 16'h3000, 16'h0000, 16'h0000};
		rdc(5'h01, 16'h794D);
		phm_host_inst.wr(5'h01, 16'h0000);
		phm_host_inst.wr(5'h10, 16'hFFFF);
		for (int k = 0; k < 11; k++)
			rdc(a[k], e[k]);
	endtask
	task automatic t_latch();
		@(negedge mclk);
		ev = 4'hF;
		link_up = 1'b0;
		an_done = 1'b1;
		@(negedge mclk);
		ev = 4'h0;
		link_up = 1'b1;
		rdc(5'h01, 16'h797B);
		rdc(5'h01, 16'h796D);
		rdc(5'h06, 16'h0017);
		rdc(5'h06, 16'h0005);
	endtask
	task automatic t_partner();
		lp_page = 16'h0DE1;
		lp_np_able = 1'b1;
		lp_an_able = 1'b0;
		pulse(lp_page_valid);
		lp_page = 16'hF21E;
		rdc(5'h05, 16'h4DE1);
		rdc(5'h06, 16'h000C);
	endtask
	task automatic t_adv();
		logic [15:0] w;
		for (int p = 0; p < 4; p++) begin
			w = 16'h01E1 | (16'(p) << 10) | (16'(p & 1) << 13);
			phm_host_inst.wr(5'h04, w);
			chk("adv_word", w, adv_word);
		end
		phm_host_inst.wr(5'h04, 16'hFFFF);
		rdc(5'h04, 16'hADFF);
	endtask
	task automatic t_np();
		phm_host_inst.wr(5'h07, 16'h97FF);
		rdc(5'h07, 16'h97FF);
		pulse(np_sent);
		rdc(5'h07, 16'h9FFF);
		phm_host_inst.wr(5'h07, 16'h0800);
		chk("np_word", 16'h0800, np_word);
	endtask
	task automatic t_ctrl();
		logic [15:0] c[4] = '{16'h0140, 16'h2100, 16'h0000, 16'h2140};
		logic [1:0] s[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
		for (int k = 0; k < 4; k++) begin
			phm_host_inst.wr(5'h00, c[k]);
			chk("forced", {11'h0, s[k], c[k][8], 2'h0}, {11'h0, speed_sel, duplex_full,
				mdix_auto, an_enable});
		end
		phm_host_inst.wr(5'h00, 16'h5500);
		chk("modes", 16'h000F, {12'h0, loopback, isolate, an_enable, mdix_auto});
		repeat (2) @(negedge mclk);
		chk("speed_sel", {14'h0, an_speed}, {14'h0, speed_sel});
		phm_host_inst.wr(5'h1C, 16'h00C0);
		chk("mdix", 16'h0002, {14'h0, mdix_manual_sel, mdix_auto});
		rdc(5'h1C, 16'h00C0);
		phm_host_inst.wr(5'h00, 16'h1300);
		chk("restart", 16'h0001, {13'h0, loopback, isolate, an_restart});
		rdc(5'h00, 16'h1100);
	endtask
	task automatic t_pdown();
		phm_host_inst.wr(5'h00, 16'h1900);
		chk("power_down", 16'h0001, {15'h0, power_down});
		rdm(5'h01, 16'h796D, phm_host_inst.PD_STAT_MASK);
		strap = 1'b0;
		phm_host_inst.wr(5'h00, 16'h1100);
		chk("power_down", 16'h0000, {15'h0, power_down});
		wait_cr(1'b1);
		wait_cr(1'b0);
		phm_host_inst.settle(HOLD);
		rdc(5'h00, 16'h1100);
		rdc(5'h04, 16'h01E1);
	endtask
	task automatic t_soft();
		strap = 1'b1;
		phm_host_inst.wr(5'h04, 16'h0DE1);
		phm_host_inst.wr(5'h00, 16'h8000);
		wait_cr(1'b1);
		wait_cr(1'b0);
		rdc(5'h00, 16'h1140);
		rdc(5'h04, 16'h01E1);
	endtask
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		strap = 1'b1;
		ev = 4'h0;
		link_up = 1'b1;
		an_done = 1'b0;
		an_speed = 2'h2;
		an_duplex = 1'b1;
		lp_page_valid = 1'b0;
		lp_page = 16'h0000;
		lp_np_able = 1'b0;
		lp_an_able = 1'b1;
		np_sent = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		t_defaults();
		t_latch();
		t_partner();
		t_adv();
		t_np();
		t_ctrl();
		t_pdown();
		t_soft();
		test_done();
	end
endmodule
